/* src/u4m_top.sv */
// four-mode serial port with multiprocessor address recognition
// Behaviour
// - synchronous mode: data both ways on rx pin, shift clock on tx pin, always master
// - synchronous write sends 8 bits lsb first; tx done after eighth bit time
// - synchronous receive runs while enabled and rx done clear; flag one cycle later
// - synchronous shift clock is system clock divided by 12
// - synchronous mode drives the rx pin open-drain, only pulling low
// - 8-bit frame: start, eight data lsb first, stop; tx pin out, rx pin in
// - async write starts sending; tx done set at start of stop bit
// - async receiver accepts frames any time while receive is enabled
// - 8-bit mode loads byte, stop bit, rx done only if free and, with multiproc on, stop valid
// - timer 1 to 4 overflow sources chosen separately for tx and rx
// - one baud tick per selected timer rollover, per second rollover for timer 1 when not doubled
// - timer 1 source: bit rate is overflow rate over 32, or 16 when doubled
// - timers 2 to 4: bit rate is overflow rate over 16
// - 9-bit frame: ninth bit from tx ninth bit; received ninth kept, stop ignored
// - 9-bit load only if free and either multiproc off or ninth set and address matches
// - fixed 9-bit mode runs at system clock over 64, or over 32 when doubled
// - variable 9-bit mode: 9-bit framing with timer overflow bit rate
// - address bytes carry ninth bit one, data bytes zero
// - masked address compares only where the mask holds one
// - with multiproc on in 9-bit modes, bytes without ninth bit set and match are dropped silently
// - interrupt requested when enabled and either done flag is set
// - broadcast address is address or mask, zero bits don't care
// - done flags cleared only by software, never on interrupt entry
// - overrun raised when a byte is latched before the previous one was read
`timescale 1ns/1ps

module u4m_tick
  import u4m_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] timer_ovf_in,
  input  wire logic [1:0] sel_in,
  input  wire logic       dbl_in,
  input  wire logic       fixed_in,
  input  wire logic       fixed_pulse_in,
  output logic            tick_out
);
  logic half_q, half_d, tick_d;

  always_comb begin
    half_d = half_q;
    tick_d = 1'b0;
    if (fixed_in) begin
      tick_d = fixed_pulse_in;
    end else if (timer_ovf_in[sel_in]) begin
      if (sel_in == U4M_SEL_TIMER1 && !dbl_in) begin
        half_d = ~half_q;
        tick_d = half_q;
      end else begin
        tick_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      half_q   <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      half_q   <= half_d;
      tick_out <= tick_d;
    end
  end
endmodule : u4m_tick

module u4m_top
  import u4m_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire u4m_cfg_t   cfg_in,
  input  wire u4m_addr_t  addr_in,
  input  wire logic [3:0] timer_ovf_in,
  input  wire logic       data_wr_in,
  input  wire logic [7:0] data_wr_data_in,
  input  wire logic       data_rd_in,
  input  wire logic       tx_done_clr_in,
  input  wire logic       rx_done_clr_in,
  input  wire logic       rx_overrun_clr_in,
  input  wire logic       int_enable_in,
  input  wire logic       serial_rx_pin_in,
  output logic            serial_rx_pin_out,
  output logic            serial_rx_pin_oe_out,
  output logic            serial_tx_pin_out,
  output logic [7:0]      serial_data_buffer_out,
  output logic            rx_ninth_bit_out,
  output logic            tx_done_flag_out,
  output logic            rx_done_flag_out,
  output logic            rx_overrun_out,
  output logic            irq_out
);
  typedef enum {M0_IDLE, M0_TX, M0_RX} u4m_sync_st_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA} u4m_rx_st_t;

  logic         sync_mode, nine_mode, tx_tick, rx_tick, fix_pulse;
  logic [1:0]   fix_q, fix_d;
  u4m_sync_st_t m0_q, m0_d;
  logic [3:0]   ph_q, ph_d;
  logic [2:0]   m0_bit_q, m0_bit_d;
  logic [7:0]   m0_sh_q, m0_sh_d;
  logic         m0_fin_q, m0_fin_d, m0_tx_set;
  logic         tx_busy_q, tx_busy_d, tx_set;
  logic [3:0]   tx_cnt_q, tx_cnt_d, tx_idx_q, tx_idx_d, stop_idx;
  logic [10:0]  tx_sh_q, tx_sh_d;
  u4m_rx_st_t   rx_q, rx_d;
  logic [3:0]   rx_cnt_q, rx_cnt_d, rx_idx_q, rx_idx_d;
  logic [8:0]   rx_sh_q, rx_sh_d;
  logic         rx_accept, addr_match;
  logic [7:0]   bcast;
  logic         tx_pin_d, oe_d, txf_d, rxf_d, ovr_d, unread_q, unread_d, b8_d;
  logic [7:0]   buf_d;

  assign sync_mode = (cfg_in.mode == U4M_SYNC);
  assign nine_mode = (cfg_in.mode == U4M_FIX9) || (cfg_in.mode == U4M_VAR9);
  assign stop_idx  = nine_mode ? U4M_STOP_IDX_9 : U4M_STOP_IDX_8;
  // fixed rate: tick every 4 or 2 clocks, 16 ticks per bit
  assign fix_pulse = (fix_q == (cfg_in.baud_double_bit ? U4M_FIX_FAST_LAST
                                                        : U4M_FIX_SLOW_LAST));
  assign fix_d     = fix_pulse ? 2'h0 : fix_q + 2'h1;

  // independent tx and rx sources, tick per rollover, per second rollover on timer 1 when not doubled
  u4m_tick u_tx_tick (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .timer_ovf_in   (timer_ovf_in),
    .sel_in         (cfg_in.tx_baud_sel),
    .dbl_in         (cfg_in.baud_double_bit),
    .fixed_in       (cfg_in.mode == U4M_FIX9),
    .fixed_pulse_in (fix_pulse),
    .tick_out       (tx_tick)
  );
  // variable 9-bit shares timer ticks with 8-bit mode
  u4m_tick u_rx_tick (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .timer_ovf_in   (timer_ovf_in),
    .sel_in         (cfg_in.rx_baud_sel),
    .dbl_in         (cfg_in.baud_double_bit),
    .fixed_in       (cfg_in.mode == U4M_FIX9),
    .fixed_pulse_in (fix_pulse),
    .tick_out       (rx_tick)
  );

  // synchronous shifter; half duplex, a write wins over a pending receive
  always_comb begin
    m0_d      = m0_q;
    ph_d      = ph_q;
    m0_bit_d  = m0_bit_q;
    m0_sh_d   = m0_sh_q;
    m0_fin_d  = 1'b0;
    m0_tx_set = 1'b0;
    unique case (m0_q)
      M0_IDLE: begin
        ph_d     = 4'h0;
        m0_bit_d = 3'h0;
        if (sync_mode && data_wr_in) begin
          m0_d    = M0_TX;
          m0_sh_d = data_wr_data_in;
        end else if (sync_mode && cfg_in.rx_enable_bit && !rx_done_flag_out && !m0_fin_q) begin
          // receive while enabled and flag clear
          m0_d = M0_RX;
        end
      end
      M0_TX: begin
        ph_d = (ph_q == U4M_SHIFT_LAST) ? 4'h0 : ph_q + 4'h1;
        if (ph_q == U4M_SHIFT_LAST) begin
          m0_sh_d  = {1'b1, m0_sh_q[7:1]};
          m0_bit_d = m0_bit_q + 3'h1;
          if (m0_bit_q == U4M_SYNC_LAST_BIT) begin
            // done at end of eighth bit time
            m0_tx_set = 1'b1;
            m0_d      = M0_IDLE;
          end
        end
      end
      M0_RX: begin
        ph_d = (ph_q == U4M_SHIFT_LAST) ? 4'h0 : ph_q + 4'h1;
        if (ph_q == U4M_SHIFT_RISE) begin
          m0_sh_d = {serial_rx_pin_in, m0_sh_q[7:1]};
          if (m0_bit_q == U4M_SYNC_LAST_BIT) begin
            m0_fin_d = 1'b1;
            m0_d     = M0_IDLE;
          end
        end
        if (ph_q == U4M_SHIFT_LAST) begin
          m0_bit_d = m0_bit_q + 3'h1;
        end
      end
    endcase
  end

  // async transmitter
  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d  = tx_cnt_q;
    tx_idx_d  = tx_idx_q;
    tx_sh_d   = tx_sh_q;
    tx_set    = 1'b0;
    if (!tx_busy_q) begin
      if (!sync_mode && data_wr_in) begin
        // start, data lsb first, ninth or stop, stop
        tx_busy_d = 1'b1;
        tx_cnt_d  = 4'h0;
        tx_idx_d  = 4'h0;
        tx_sh_d   = {1'b1, nine_mode ? cfg_in.tx_ninth_bit : 1'b1, data_wr_data_in, 1'b0};
      end
    end else if (tx_tick) begin
      tx_cnt_d = tx_cnt_q + 4'h1;
      if (tx_cnt_q == U4M_OVS_LAST) begin
        tx_sh_d  = {1'b1, tx_sh_q[10:1]};
        tx_idx_d = tx_idx_q + 4'h1;
        // done flag at start of stop bit
        tx_set   = (tx_idx_q + 4'h1 == stop_idx);
        if (tx_idx_q == stop_idx) begin
          tx_busy_d = 1'b0;
        end
      end
    end
  end

  assign bcast      = addr_in.slave_address_reg | addr_in.slave_address_mask_reg;
  assign addr_match = (((rx_sh_q[7:0] ^ addr_in.slave_address_reg)
                        & addr_in.slave_address_mask_reg) == 8'h00)
                   || (((rx_sh_q[7:0] ^ bcast) & bcast) == 8'h00);

  // async receiver
  always_comb begin
    rx_d      = rx_q;
    rx_cnt_d  = rx_cnt_q;
    rx_idx_d  = rx_idx_q;
    rx_sh_d   = rx_sh_q;
    rx_accept = 1'b0;
    unique case (rx_q)
      RX_IDLE: begin
        if (!sync_mode && cfg_in.rx_enable_bit && !serial_rx_pin_in) begin
          rx_d     = RX_START;
          rx_cnt_d = 4'h0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == U4M_OVS_MID) begin
            // a glitch shorter than half a bit is not a start bit
            rx_d     = serial_rx_pin_in ? RX_IDLE : RX_DATA;
            rx_cnt_d = 4'h0;
            rx_idx_d = 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == U4M_OVS_LAST) begin
            rx_cnt_d = 4'h0;
            rx_idx_d = rx_idx_q + 4'h1;
            if (rx_idx_q <= U4M_NINTH_IDX) begin
              rx_sh_d[rx_idx_q - 4'h1] = serial_rx_pin_in;
            end
            if (rx_idx_q == stop_idx) begin
              rx_d = RX_IDLE;
              if (nine_mode) begin
                // stop ignored; ninth set marks address, must match
                rx_accept = !rx_done_flag_out &&
                            (!cfg_in.multiproc_enable || (rx_sh_q[8] && addr_match));
              end else begin
                // stop bit must be high under multiproc
                rx_accept = !rx_done_flag_out &&
                            (!cfg_in.multiproc_enable || serial_rx_pin_in);
              end
            end
          end
        end
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  // flags, buffer and pins
  always_comb begin
    buf_d    = serial_data_buffer_out;
    b8_d     = rx_ninth_bit_out;
    unread_d = unread_q && !data_rd_in;
    ovr_d    = rx_overrun_out && !rx_overrun_clr_in;
    if (rx_accept) begin
      buf_d = rx_sh_d[7:0];
      // stop bit in 8-bit mode, ninth bit otherwise
      b8_d  = nine_mode ? rx_sh_q[8] : serial_rx_pin_in;
    end else if (m0_fin_q) begin
      buf_d = m0_sh_q;
    end
    if (rx_accept || m0_fin_q) begin
      unread_d = 1'b1;
      // overrun when previous byte unread; set beats clear
      ovr_d    = rx_overrun_out || unread_q;
    end
    // cleared only by software, set wins over clear
    txf_d = (tx_done_flag_out && !tx_done_clr_in) || tx_set || m0_tx_set;
    rxf_d = (rx_done_flag_out && !rx_done_clr_in) || rx_accept || m0_fin_q;
    if (sync_mode) begin
      // shift clock on tx pin, low first half of each bit
      tx_pin_d = (m0_d == M0_IDLE) || (ph_d >= U4M_SHIFT_RISE);
      // open drain: only ever pull low
      oe_d     = (m0_d == M0_TX) && !m0_sh_d[0];
    end else begin
      tx_pin_d = tx_busy_d ? tx_sh_d[0] : U4M_LINE_IDLE;
      oe_d     = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fix_q                  <= 2'h0;
      m0_q                   <= M0_IDLE;
      ph_q                   <= 4'h0;
      m0_bit_q               <= 3'h0;
      m0_sh_q                <= U4M_BUF_RST;
      m0_fin_q               <= 1'b0;
      tx_busy_q              <= 1'b0;
      tx_cnt_q               <= 4'h0;
      tx_idx_q               <= 4'h0;
      tx_sh_q                <= 11'h7ff;
      rx_q                   <= RX_IDLE;
      rx_cnt_q               <= 4'h0;
      rx_idx_q               <= 4'h0;
      rx_sh_q                <= 9'h000;
      unread_q               <= 1'b0;
      serial_data_buffer_out <= U4M_BUF_RST;
      rx_ninth_bit_out       <= 1'b0;
      tx_done_flag_out       <= 1'b0;
      rx_done_flag_out       <= 1'b0;
      rx_overrun_out         <= 1'b0;
      serial_tx_pin_out      <= U4M_LINE_IDLE;
      serial_rx_pin_out      <= 1'b0;
      serial_rx_pin_oe_out   <= 1'b0;
      irq_out                <= 1'b0;
    end else begin
      fix_q                  <= fix_d;
      m0_q                   <= m0_d;
      ph_q                   <= ph_d;
      m0_bit_q               <= m0_bit_d;
      m0_sh_q                <= m0_sh_d;
      m0_fin_q               <= m0_fin_d;
      tx_busy_q              <= tx_busy_d;
      tx_cnt_q               <= tx_cnt_d;
      tx_idx_q               <= tx_idx_d;
      tx_sh_q                <= tx_sh_d;
      rx_q                   <= rx_d;
      rx_cnt_q               <= rx_cnt_d;
      rx_idx_q               <= rx_idx_d;
      rx_sh_q                <= rx_sh_d;
      unread_q               <= unread_d;
      serial_data_buffer_out <= buf_d;
      rx_ninth_bit_out       <= b8_d;
      tx_done_flag_out       <= txf_d;
      rx_done_flag_out       <= rxf_d;
      rx_overrun_out         <= ovr_d;
      serial_tx_pin_out      <= tx_pin_d;
      serial_rx_pin_out      <= 1'b0;
      serial_rx_pin_oe_out   <= oe_d;
      irq_out                <= int_enable_in && (txf_d || rxf_d);
    end
  end
endmodule : u4m_top

/* src/u4m_pkg.sv */
// shared types and constants of the four-mode serial port
package u4m_pkg;

  // mode field values 0 to 3 in this order
  typedef enum logic [1:0] {U4M_SYNC, U4M_ASYNC8, U4M_FIX9, U4M_VAR9} u4m_mode_t;

  typedef struct packed {
    u4m_mode_t  mode;
    logic       multiproc_enable;
    logic       rx_enable_bit;
    logic       tx_ninth_bit;
    logic       baud_double_bit;
    logic [1:0] tx_baud_sel;
    logic [1:0] rx_baud_sel;
  } u4m_cfg_t;

  typedef struct packed {
    logic [7:0] slave_address_reg;
    logic [7:0] slave_address_mask_reg;
  } u4m_addr_t;

  // synchronous shift clock: 12 system clocks per bit, rising edge at count 6
  localparam logic [3:0] U4M_SHIFT_LAST = 4'hb;
  localparam logic [3:0] U4M_SHIFT_RISE = 4'h6;
  localparam logic [2:0] U4M_SYNC_LAST_BIT = 3'h7;
  // 16 oversample ticks per bit, start bit checked mid-bit
  localparam logic [3:0] U4M_OVS_LAST = 4'hf;
  localparam logic [3:0] U4M_OVS_MID = 4'h7;
  // fixed-rate tick: 64 or 32 clocks per bit over 16 ticks
  localparam logic [1:0] U4M_FIX_SLOW_LAST = 2'h3;
  localparam logic [1:0] U4M_FIX_FAST_LAST = 2'h1;
  // frame positions: 8-bit frame stop at 9, 9-bit frame stop at 10
  localparam logic [3:0] U4M_STOP_IDX_8 = 4'h9;
  localparam logic [3:0] U4M_STOP_IDX_9 = 4'ha;
  localparam logic [3:0] U4M_NINTH_IDX = 4'h9;
  // timer 1 is select code 0
  localparam logic [1:0] U4M_SEL_TIMER1 = 2'h0;
  // reset values
  localparam logic       U4M_LINE_IDLE = 1'b1;
  localparam logic [7:0] U4M_BUF_RST = 8'h00;

endpackage : u4m_pkg

/* dv/u4m_checker.sv */
// assertion checker watching the serial port top ports
`timescale 1ns/1ps
module u4m_checker
  import u4m_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire u4m_cfg_t   cfg_in,
  input wire logic       int_enable_in,
  input wire logic       tx_done_clr_in,
  input wire logic       rx_done_clr_in,
  input wire logic       serial_rx_pin_out,
  input wire logic       serial_rx_pin_oe_out,
  input wire logic       serial_tx_pin_out,
  input wire logic [7:0] serial_data_buffer_out,
  input wire logic       tx_done_flag_out,
  input wire logic       rx_done_flag_out,
  input wire logic       rx_overrun_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  irq_raise_a: assert property (
    (tx_done_flag_out || rx_done_flag_out) && $past(int_enable_in) |-> irq_out)
    else $error("interrupt missing");
  irq_cause_a: assert property (
    irq_out |-> tx_done_flag_out || rx_done_flag_out) else $error("interrupt without flag");
  tx_flag_hold_a: assert property (
    $past(tx_done_flag_out) && !$past(tx_done_clr_in) |-> tx_done_flag_out)
    else $error("tx done lost");
  rx_flag_hold_a: assert property (
    $past(rx_done_flag_out) && !$past(rx_done_clr_in) |-> rx_done_flag_out)
    else $error("rx done lost");
  // low half lasts six clocks, then high
  shift_clock_a: assert property (
    $fell(serial_tx_pin_out) && cfg_in.mode == U4M_SYNC
    |-> !serial_tx_pin_out [*6] ##1 serial_tx_pin_out) else $error("shift clock shape");
  drain_only_a: assert property (
    serial_rx_pin_oe_out |-> !serial_rx_pin_out && cfg_in.mode == U4M_SYNC)
    else $error("data pin driven wrongly");
  rx_enabled_a: assert property (
    $rose(rx_done_flag_out) |-> $past(cfg_in.rx_enable_bit)) else $error("rx while off");
  buf_load_a: assert property (
    $changed(serial_data_buffer_out) |-> $rose(rx_done_flag_out))
    else $error("buffer changed without load");
  overrun_load_a: assert property (
    $rose(rx_overrun_out) |-> $rose(rx_done_flag_out)) else $error("overrun without load");
  tx_end_a: assert property (
    $rose(tx_done_flag_out) |-> serial_tx_pin_out && !serial_rx_pin_oe_out)
    else $error("tx done before line idle");
endmodule : u4m_checker

bind u4m_top u4m_checker u_chk (.clk_in, .rst_n_in, .cfg_in, .int_enable_in,
  .tx_done_clr_in, .rx_done_clr_in, .serial_rx_pin_out, .serial_rx_pin_oe_out,
  .serial_tx_pin_out, .serial_data_buffer_out, .tx_done_flag_out, .rx_done_flag_out,
  .rx_overrun_out, .irq_out);

/* dv/u4m_peer.sv */
// remote serial device driving the shared rx line
`timescale 1ns/1ps
module u4m_peer (
  input  wire logic clk_in,
  input  wire logic shift_clk_in,
  output logic      pull_low_out
);
  logic       a_low   = 1'h0;
  logic       s_low   = 1'h0;
  logic       sync_on = 1'h0;
  logic [7:0] s_byte  = 8'h00;
  // released line floats high through the pullup
  assign pull_low_out = a_low | s_low;
  // start, data lsb first, ninth, stop
  task automatic send(input logic [10:0] f, input int nb, input int per);
    @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      a_low <= ~f[i];
      repeat (per) @(posedge clk_in);
    end
    a_low <= 1'h0;
  endtask : send
  always @(negedge shift_clk_in) begin
    if (sync_on) begin
      s_low  <= ~s_byte[0];
      s_byte <= s_byte >> 1;
    end
  end
  task automatic sync_load(input logic [7:0] b);
    s_byte  = b;
    sync_on = 1'h1;
  endtask : sync_load
  task automatic sync_stop;
    sync_on = 1'h0;
    s_low   <= 1'h0;
  endtask : sync_stop
endmodule : u4m_peer

/* dv/tb_top.sv */
// self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module tb_top;
  import u4m_pkg::*;
  logic       clk_in   = 1'h0;
  logic       rst_n_in = 1'h0;
  u4m_cfg_t   cfg      = '0;
  u4m_addr_t  addr     = '0;
  logic [3:0] ovf      = 4'h0;
  logic [3:0] ovf_mask = 4'h0;
  logic [7:0] wdat     = 8'h00;
  logic [4:0] pls      = 5'h00;
  wire        wr = pls[0], rd = pls[1], txc = pls[2], rxc = pls[3], ovc = pls[4];
  localparam logic [4:0] PL_WR = 5'h01, PL_RD = 5'h02, PL_TXC = 5'h04;
  localparam logic [4:0] PL_RXC = 5'h08, PL_OVC = 5'h10;
  logic       ien      = 1'h1;
  logic       rx_o, oe, tx_pin, ninth, txd, rxd, ovr, irq, peer_low;
  logic [7:0] buf_q;
  // open-drain line with pullup: low only while a side pulls it
  wire        rx_line  = ~((oe & ~rx_o) | peer_low);
  int         errors   = 0;
  int         n_compared = 0;

  always #25 clk_in = ~clk_in;
  // one pulse per rollover, every other clock
  always @(posedge clk_in) ovf <= (ovf == 4'h0) ? ovf_mask : 4'h0;

  u4m_top DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg), .addr_in(addr),
    .timer_ovf_in(ovf), .data_wr_in(wr), .data_wr_data_in(wdat), .data_rd_in(rd),
    .tx_done_clr_in(txc), .rx_done_clr_in(rxc), .rx_overrun_clr_in(ovc),
    .int_enable_in(ien), .serial_rx_pin_in(rx_line), .serial_rx_pin_out(rx_o),
    .serial_rx_pin_oe_out(oe), .serial_tx_pin_out(tx_pin), .serial_data_buffer_out(buf_q),
    .rx_ninth_bit_out(ninth), .tx_done_flag_out(txd), .rx_done_flag_out(rxd),
    .rx_overrun_out(ovr), .irq_out(irq));
  u4m_peer peer (.clk_in(clk_in), .shift_clk_in(tx_pin), .pull_low_out(peer_low));

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  // one-cycle pulse on the strobes selected by m
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_in);
    pls <= m;
    @(posedge clk_in);
    pls <= 5'h00;
  endtask : pulse

  // bounded wait on the tx pin or the rx done flag, sampled at the falling edge
  task automatic wt(input bit w, input logic v, output int n);
    for (n = 1; n < 400; n++) begin
      @(negedge clk_in);
      if ((w ? rxd : tx_pin) === v) return;
    end
    errors++;
    $display("wrong value at %0t ns: wait ran out", $time);
    conclude;
  endtask : wt

  task automatic t_sync;
    int n, n1, n2;
    @(posedge clk_in);
    wdat <= 8'h5a;
    pulse(PL_WR);
    wt(0, 1'h0, n);
    for (int i = 0; i < 8; i++) begin
      repeat (3) @(negedge clk_in);
      chk(8'(oe), 8'(!wdat[i]), "pull low");
      chk(8'(rx_o), 8'h00, "drain level");
      chk(8'(rx_line), 8'(wdat[i]), "data pin");
      wt(0, 1'h1, n1);
      if (i < 7) begin
        wt(0, 1'h0, n2);
        chk(8'(n1 + n2 + 3), 8'h0c, "shift period");
      end
    end
    repeat (2) @(negedge clk_in);
    chk(8'(txd), 8'h00, "tx done early");
    repeat (6) @(negedge clk_in);
    chk({6'h00, txd, irq}, 8'h03, "sync tx end");
    // enable gates the request only, the flag stays
    @(posedge clk_in);
    ien <= 1'h0;
    repeat (2) @(negedge clk_in);
    chk({6'h00, txd, irq}, 8'h02, "irq masked");
    @(posedge clk_in);
    ien <= 1'h1;
    pulse(PL_TXC);
    peer.sync_load(8'h96);
    cfg.rx_enable_bit <= 1'h1;
    wt(1, 1'h1, n);
    chk(buf_q, 8'h96, "sync rx byte");
    repeat (3) @(negedge clk_in);
    chk(8'(tx_pin), 8'h01, "rx halted");
    @(posedge clk_in);
    cfg.rx_enable_bit <= 1'h0;
    peer.sync_stop;
    pulse(PL_RXC);
    pulse(PL_RD);
    $display("sync test done");
  endtask : t_sync

  task automatic t_atx(input u4m_mode_t m, input logic [1:0] sel, input logic [3:0] msk,
                       input int per, input logic [8:0] d);
    int nb, n;
    logic [10:0] f;
    nb = (m == U4M_ASYNC8) ? 10 : 11;
    f  = (m == U4M_ASYNC8) ? {2'h3, d[7:0], 1'h0} : {1'h1, d, 1'h0};
    @(posedge clk_in);
    cfg <= '{mode: m, tx_ninth_bit: d[8], baud_double_bit: per == 32, tx_baud_sel: sel,
             default: '0};
    ovf_mask <= msk;
    wdat <= d[7:0];
    pulse(PL_WR);
    wt(0, 1'h0, n);
    repeat (per / 2) @(negedge clk_in);
    for (int i = 0; i < nb; i++) begin
      chk(8'(tx_pin), 8'(f[i]), "frame bit");
      chk(8'(txd), 8'(i == nb - 1), "tx done");
      if (i < nb - 1) repeat (per) @(negedge clk_in);
    end
    chk(8'(irq), 8'h01, "irq set");
    pulse(PL_TXC);
    @(negedge clk_in);
    chk({6'h00, txd, irq}, 8'h00, "flag cleared");
    repeat (per) @(negedge clk_in);
    $display("async tx test done");
  endtask : t_atx

  // e holds expected rx done, ninth bit and byte
  task automatic rx1(input logic [10:0] f, input int nb, input logic [9:0] e);
    peer.send(f, nb, 32);
    @(negedge clk_in);
    chk(8'(rxd), 8'(e[9]), "rx done");
    chk(buf_q, e[7:0], "rx byte");
    chk(8'(ninth), 8'(e[8]), "ninth bit");
  endtask : rx1

  task automatic t_mp;
    @(posedge clk_in);
    cfg <= '{mode: U4M_FIX9, rx_enable_bit: 1'h1, baud_double_bit: 1'h1, default: '0};
    addr <= {8'h35, 8'h0f};
    rx1({1'h1, 9'h0a5, 1'h0}, 11, 10'h2a5);
    rx1({1'h1, 9'h0c3, 1'h0}, 11, 10'h2a5);
    pulse(PL_RXC);
    cfg.multiproc_enable <= 1'h1;
    rx1({1'h1, 9'h035, 1'h0}, 11, 10'h0a5);
    rx1({1'h1, 9'h1f4, 1'h0}, 11, 10'h0a5);
    rx1({1'h1, 9'h1f5, 1'h0}, 11, 10'h3f5);
    chk(8'(ovr), 8'h01, "overrun set");
    pulse(PL_RXC);
    pulse(PL_RD);
    pulse(PL_OVC);
    rx1({1'h1, 9'h1ff, 1'h0}, 11, 10'h3ff);
    chk(8'(ovr), 8'h00, "no overrun");
    pulse(PL_RXC);
    cfg.multiproc_enable <= 1'h0;
    rx1({1'h1, 9'h011, 1'h0}, 11, 10'h211);
    pulse(PL_RXC);
    // receiver alone on timer 3, transmit source left on timer 1
    cfg <= '{mode: U4M_ASYNC8, rx_enable_bit: 1'h1, multiproc_enable: 1'h1,
             baud_double_bit: 1'h1, rx_baud_sel: 2'h2, default: '0};
    ovf_mask <= 4'h4;
    rx1({2'h1, 8'h66, 1'h0}, 10, 10'h366);
    $display("multiprocessor rx test done");
  endtask : t_mp

  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'h1;
    @(negedge clk_in);
    chk({2'h0, tx_pin, oe, txd, rxd, ovr, irq}, 8'h20, "reset state");
    t_sync;
    t_atx(U4M_ASYNC8, 2'h0, 4'h1, 32, 9'h0a5);
    t_atx(U4M_ASYNC8, 2'h0, 4'h1, 64, 9'h03c);
    t_atx(U4M_FIX9, 2'h0, 4'h0, 32, 9'h1c3);
    t_atx(U4M_FIX9, 2'h0, 4'h0, 64, 9'h05a);
    t_atx(U4M_VAR9, 2'h1, 4'h2, 32, 9'h17e);
    t_atx(U4M_VAR9, 2'h3, 4'h8, 32, 9'h081);
    t_mp;
    conclude;
  end
endmodule : tb_top
